// file: sim/far_end.sv
// Purpose: Far-side serial device for the serial port bench
// Assumes: Sees pin levels, runs on the system clock
// Notes: Drives clocks only when asked; data line flips between frames
`timescale 1ns/1ps
module far_end (
  input wire logic clock,
  input wire logic rst,
  input wire logic sck,
  input wire logic dut_sdo,
  input wire logic lsb_first,
  input wire logic go,
  input wire logic drive_clk,
  input wire logic [7:0] tx_byte,
  output logic gen_sck,
  output logic far_sdo,
  output logic [7:0] rx_byte,
  output logic busy
);
  logic sck_q;
  logic [7:0] tx_r;
  logic [2:0] fcnt;
  logic [2:0] rcnt;
  logic [2:0] nbit;
  logic [1:0] tick;
  // ==========================================================
  // Clock maker, four system cycles a phase, idles high
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gen_sck <= 1'b1;
      busy <= 1'b0;
      tick <= 2'h0;
      nbit <= 3'h0;
    end else if (go) begin
      busy <= drive_clk;
      tick <= 2'h0;
      nbit <= 3'h0;
    end else if (busy) begin
      tick <= tick + 2'h1;
      if (tick == 2'h3) begin
        gen_sck <= ~gen_sck;
        if (!gen_sck) begin
          nbit <= nbit + 3'h1;
          busy <= (nbit != 3'h7);
        end
      end
    end
  end
  // Shift out on falling edges, sample on rising edges
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sck_q <= 1'b1;
      far_sdo <= 1'b1;
      tx_r <= 8'h00;
      fcnt <= 3'h0;
      rcnt <= 3'h0;
      rx_byte <= 8'h00;
    end else begin
      sck_q <= sck;
      if (go) begin
        tx_r <= tx_byte;
        fcnt <= 3'h0;
        rcnt <= 3'h0;
        far_sdo <= ~far_sdo;
      end else if (sck_q && !sck) begin
        far_sdo <= tx_r[lsb_first ? fcnt : 3'h7 - fcnt];
        fcnt <= fcnt + 3'h1;
      end else if (!sck_q && sck) begin
        rx_byte[lsb_first ? rcnt : 3'h7 - rcnt] <= dut_sdo;
        rcnt <= rcnt + 3'h1;
      end
    end
  end
endmodule

// file: sim/tb_top.sv
// Purpose: Self-checking bench for the serial port block
// Assumes: Far device modelled by far_end on the pins
// Notes: Master received data checked at divide 16 only, divide 2 samples late
`timescale 1ns/1ps
module tb_top;
  logic clock, rst, bus_rd, bus_wr, stop_mode, rx_ready, go, far_lsb, far_drive, sck_w;
  logic sck_out, sck_oe_n, sdo_out, sdo_oe_n, irq, rx_valid, far_sck, far_sdo, far_busy;
  logic [7:0] bus_addr, bus_wdata, bus_rdata, rx_data, far_tx, far_rx, q, moved, b;
  logic [8:0] exp_q[$];
  logic [31:0] seed;
  int mismatches, checked, i, n;
  assign sck_w = sck_oe_n ? far_sck : sck_out;
  serial_port DUT (.clock(clock), .rst(rst), .bus_addr(bus_addr), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .sck_in(sck_w),
    .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdi_in(far_sdo), .sdo_out(sdo_out),
    .sdo_oe_n(sdo_oe_n), .stop_mode(stop_mode), .serial_interrupt_request(irq),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));
  far_end far (.clock(clock), .rst(rst), .sck(sck_w), .dut_sdo(sdo_out), .lsb_first(far_lsb),
    .go(go), .drive_clk(far_drive), .tx_byte(far_tx), .gen_sck(far_sck), .far_sdo(far_sdo),
    .rx_byte(far_rx), .busy(far_busy));
  // ==========================================================
  // Clock, helpers and bus access
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  function automatic logic [7:0] st(input logic d, c);
    return {d, c, 6'h00};
  endfunction
  task automatic check(input string what, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge clock);
    #1;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge clock);
    bus_addr <= a;
    bus_wr <= w;
    bus_rd <= ~w;
    bus_wdata <= d;
    @(posedge clock);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    #1 q = bus_rdata;
  endtask
  task automatic watch(input int cyc);
    logic [2:0] ref_v;
    moved = 8'h00;
    repeat (2) tick();
    ref_v = {sck_out, sdo_out, sck_oe_n};
    repeat (cyc) begin
      tick();
      if ({sck_out, sdo_out, sck_oe_n} !== ref_v) moved = 8'h01;
    end
  endtask
  task automatic load_far(input logic [7:0] v, input logic lsb, drv);
    @(posedge clock);
    far_tx <= v;
    far_lsb <= lsb;
    far_drive <= drv;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    #1;
    for (n = 0; drv && far_busy !== 1'b0 && n < 200; n++) tick();
  endtask
  // ==========================================================
  // Master exchange: 0 plain, 1 collision, 2 stop, 3 buffer full
  task automatic master(input logic [7:0] ctl, input int mode);
    logic [7:0] tb_b, far_b;
    tb_b = rnd();
    far_b = rnd();
    exp_q.push_back({~ctl[0], far_b});
    acc(1, serial_pkg::CTRL_OFF, ctl);
    load_far(far_b, ctl[5], 1'b0);
    acc(1, serial_pkg::DATA_OFF, tb_b);
    if (mode == 3) begin
      watch(30);
      check("start_held", moved, 8'h00);
      @(posedge clock);
      rx_ready <= 1'b1;
    end
    for (n = 0; sck_out !== 1'b0 && n < 40; n++) tick();
    for (n = 0; sck_out === 1'b0 && n < 20; n++) tick();
    check("half_period", 8'(n), ctl[0] ? 8'h08 : 8'h01);
    if (mode == 1) begin
      acc(0, serial_pkg::DATA_OFF, 8'h00);
      check("col_read", q, 8'h00);
      check("col_irq", {7'h00, irq}, 8'h00);
    end
    if (mode == 2) begin
      @(posedge clock);
      stop_mode <= 1'b1;
      watch(40);
      check("stop_hold", moved, 8'h00);
      @(posedge clock);
      stop_mode <= 1'b0;
    end
    for (n = 0; irq !== 1'b1 && n < 400; n++) tick();
    check("irq", {7'h00, irq}, 8'h01);
    repeat (2) tick();
    check("sck_idle", {7'h00, sck_out}, 8'h01);
    check("far_rx", far_rx, tb_b);
    acc(1, serial_pkg::DATA_OFF, ~tb_b);
    acc(0, serial_pkg::DATA_OFF, 8'h00);
    check("locked_read", q, 8'h00);
    acc(0, serial_pkg::STATUS_OFF, 8'h00);
    check("status_done", q, st(1'b1, mode == 1));
    acc(0, serial_pkg::DATA_OFF, 8'h00);
    if (ctl[0]) check("rx_byte", q, far_b);
    acc(0, serial_pkg::STATUS_OFF, 8'h00);
    check("status_clr", q, 8'h00);
    check("irq_clr", {7'h00, irq}, 8'h00);
    check("master_oe", {6'h00, sck_oe_n, sdo_oe_n}, 8'h00);
    $display("test master %h mode %0d done", ctl, mode);
  endtask
  // ==========================================================
  // Slave exchange, optionally in stop, then ignored extra pulses
  task automatic slave(input logic [7:0] ctl, input logic stop);
    logic [7:0] tb_b, far_b;
    tb_b = rnd();
    far_b = rnd();
    exp_q.push_back({1'b0, far_b});
    acc(1, serial_pkg::CTRL_OFF, ctl);
    acc(1, serial_pkg::DATA_OFF, tb_b);
    watch(20);
    check("slave_quiet", moved, 8'h00);
    @(posedge clock);
    stop_mode <= stop;
    load_far(far_b, ctl[5], 1'b1);
    repeat (6) tick();
    check("slave_irq", {7'h00, irq}, 8'h01);
    check("far_rx", far_rx, tb_b);
    if (stop) begin
      acc(0, serial_pkg::STATUS_OFF, 8'h00);
      check("stop_status", q, 8'h00);
      @(posedge clock);
      stop_mode <= 1'b0;
      repeat (3) tick();
    end
    load_far(rnd(), ctl[5], 1'b1);
    repeat (6) tick();
    acc(0, serial_pkg::STATUS_OFF, 8'h00);
    check("slave_status", q, st(1'b1, 1'b0));
    acc(0, serial_pkg::DATA_OFF, 8'h00);
    check("slave_rx", q, far_b);
    check("slave_oe", {6'h00, sck_oe_n, sdo_oe_n}, 8'h02);
    $display("test slave %h stop %0d done", ctl, stop);
  endtask
  // ==========================================================
  // Buffer output checked against the bytes expected
  always @(posedge clock) begin
    if (!rst && rx_valid === 1'b1 && rx_ready === 1'b1 && exp_q.size() > 0) begin
      if (!exp_q[0][8]) check("fifo_out", rx_data, exp_q[0][7:0]);
      void'(exp_q.pop_front());
    end
  end
  initial begin
    repeat (30000) @(posedge clock);
    mismatches++;
    results();
  end
  initial begin
    seed = 32'hedba_330d;
    rst = 1'b1;
    {bus_rd, bus_wr, stop_mode, go, far_lsb, far_drive} = 6'h00;
    {bus_addr, bus_wdata, far_tx} = 24'h00_0000;
    rx_ready = 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    acc(0, serial_pkg::STATUS_OFF, 8'h00);
    check("status_rst", q, 8'h00);
    check("oe_rst", {6'h00, sck_oe_n, sdo_oe_n}, 8'h03);
    acc(1, serial_pkg::STATUS_OFF, 8'hff);
    acc(0, serial_pkg::STATUS_OFF, 8'h00);
    check("status_wr", q, 8'h00);
    acc(0, 8'h0d, 8'h00);
    check("unmapped", q, 8'h00);
    acc(0, serial_pkg::CTRL_OFF, 8'h00);
    check("ctrl_rst", q, serial_pkg::CTRL_RESET);
    b = rnd();
    acc(1, serial_pkg::DATA_OFF, b);
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    acc(0, serial_pkg::DATA_OFF, 8'h00);
    check("data_keep", q, b);
    $display("test registers done");
    for (i = 0; i < 4; i++) master(8'hd0 | {2'h0, i[1], 4'h0, i[0]}, 0);
    master(8'hd1, 1);
    master(8'hd1, 2);
    slave(8'hc0, 1'b0);
    slave(8'he0, 1'b0);
    slave(8'hc0, 1'b1);
    @(posedge clock);
    rx_ready <= 1'b0;
    for (i = 0; i < 16; i++) master(8'hf1, 0);
    master(8'hd1, 3);
    for (n = 0; rx_valid !== 1'b0 && n < 100; n++) tick();
    check("fifo_empty", {7'h00, rx_valid}, 8'h00);
    check("fifo_left", 8'(exp_q.size()), 8'h00);
    results();
  end
endmodule

// file: verilog/bit_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clock
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_r;

  // ==========================================================
  // Two register stages
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage_r <= '1;
      sync_out <= '1;
    end else begin
      stage_r <= async_in;
      sync_out <= stage_r;
    end
  end
endmodule

// file: verilog/byte_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock domain
// Notes: Depth must be a power of two
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic push;
  logic pop;

  // Full and empty from pointer compare
  assign in_ready = (wr_ptr_r[AW] == rd_ptr_r[AW]) || (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]);
  assign out_valid = wr_ptr_r != rd_ptr_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_r[AW-1:0]];

  // ==========================================================
  // Storage
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule

// file: verilog/serial_pkg.sv
// Purpose: Shared constants for the byte-wide serial interface block
// Assumes: 8-bit CPU register port, 100 MHz system clock
// Notes: Offsets are the CPU byte addresses of the three registers
package serial_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] CTRL_OFF = 8'h0a;
  localparam logic [7:0] STATUS_OFF = 8'h0b;
  localparam logic [7:0] DATA_OFF = 8'h0c;

  // ==========================================================
  // Control register fields and reset value
  localparam int IRQ_EN_BIT = 7;
  localparam int SER_EN_BIT = 6;
  localparam int ORDER_BIT = 5;
  localparam int MASTER_BIT = 4;
  localparam int DIV_BIT = 0;
  localparam logic [7:0] CTRL_MASK = 8'hf1;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ==========================================================
  // Status register fields
  localparam int DONE_BIT = 7;
  localparam int COL_BIT = 6;
  localparam logic [5:0] STATUS_PAD = 6'h00;

  // ==========================================================
  // Serial clock timing
  localparam int CLOCK_MHZ = 100;
  localparam int DIV_SLOW = 16;
  localparam int DIV_FAST = 2;
  localparam logic [3:0] HALF_SLOW = 4'(DIV_SLOW / 2 - 1);
  localparam logic [3:0] HALF_FAST = 4'(DIV_FAST / 2 - 1);
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ==========================================================
  // Receive buffer shape
  localparam int BYTE_W = 8;
  localparam int RX_DEPTH = 16;
endpackage

// file: verilog/serial_port.sv
// Purpose: Byte-wide serial interface with status, data and low-power behaviour
// Assumes: CPU port on clock; serial pins asynchronous and synchronised
// Notes: Received bytes are also streamed out through a 16-byte buffer, except slave bytes that find it full
`timescale 1ns/1ps
module serial_port (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_n,
  input wire logic stop_mode,
  output logic serial_interrupt_request,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready
);
  // ==========================================================
  // Declarations
  logic [7:0] serial_control_register;
  logic [7:0] shift_data_register;
  logic transfer_done_flag;
  logic access_collision_flag;
  logic done_pend_r;
  logic armed_r;
  logic busy_r;
  logic start_pend_r;
  logic [2:0] cnt_r;
  logic [3:0] half_cnt_r;
  logic sck_r;
  logic sdo_r;
  logic push_r;
  logic sck_d_r;
  logic [1:0] pins_s;
  logic sck_s;
  logic sdi_s;
  logic transfer_irq_enable;
  logic serial_en;
  logic bit_order_select;
  logic master_select;
  logic clock_divide_select;
  logic busy_any;
  logic st_rd;
  logic dat_acc;
  logic acc_ok;
  logic seq_clr;
  logic col_evt;
  logic [3:0] half_lim;
  logic m_tick;
  logic s_en;
  logic rise;
  logic fall;
  logic last_rise;
  logic done_set;
  logic fifo_in_ready;

  // Control fields
  assign transfer_irq_enable = serial_control_register[serial_pkg::IRQ_EN_BIT];
  assign serial_en = serial_control_register[serial_pkg::SER_EN_BIT];
  assign bit_order_select = serial_control_register[serial_pkg::ORDER_BIT];
  assign master_select = serial_control_register[serial_pkg::MASTER_BIT];
  assign clock_divide_select = serial_control_register[serial_pkg::DIV_BIT];

  // ==========================================================
  // Pin synchronisers
  bit_sync #(.WIDTH(2)) u_pin_sync (
    .clock(clock),
    .rst(rst),
    .async_in({sck_in, sdi_in}),
    .sync_out(pins_s)
  );
  assign sck_s = pins_s[1];
  assign sdi_s = pins_s[0];

  // Previous synchronised clock level for edge detect
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sck_d_r <= 1'b1;
    end else begin
      sck_d_r <= sck_s;
    end
  end

  // ==========================================================
  // CPU access decode
  assign busy_any = busy_r || start_pend_r;
  assign st_rd = bus_rd && (bus_addr == serial_pkg::STATUS_OFF);
  assign dat_acc = (bus_rd || bus_wr) && (bus_addr == serial_pkg::DATA_OFF);
  assign acc_ok = dat_acc && !busy_any && (!transfer_done_flag || armed_r);
  assign seq_clr = dat_acc && transfer_done_flag && armed_r;
  assign col_evt = dat_acc && busy_any;

  // Control register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      serial_control_register <= serial_pkg::CTRL_RESET;
    end else if (bus_wr && bus_addr == serial_pkg::CTRL_OFF) begin
      serial_control_register <= bus_wdata & serial_pkg::CTRL_MASK;
    end
  end

  // Read data, registered one cycle after the strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      case (bus_addr)
        serial_pkg::CTRL_OFF: bus_rdata <= serial_control_register;
        serial_pkg::STATUS_OFF: begin
          bus_rdata <= {transfer_done_flag, access_collision_flag, serial_pkg::STATUS_PAD};
        end
        serial_pkg::DATA_OFF: bus_rdata <= acc_ok ? shift_data_register : 8'h00;
        default: bus_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Serial clock generation and edges
  assign half_lim = clock_divide_select ? serial_pkg::HALF_SLOW : serial_pkg::HALF_FAST;
  assign m_tick = serial_en && master_select && busy_r && !stop_mode
    && (half_cnt_r == half_lim);
  assign s_en = serial_en && !master_select && !transfer_done_flag && !done_pend_r;
  assign rise = master_select ? (m_tick && !sck_r) : (s_en && sck_s && !sck_d_r);
  assign fall = master_select ? (m_tick && sck_r) : (s_en && !sck_s && sck_d_r);
  assign last_rise = rise && busy_r && (cnt_r == serial_pkg::LAST_BIT);
  assign done_set = (last_rise && !(stop_mode && !master_select))
    || (done_pend_r && !stop_mode);

  // Half-period divider for the master clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      half_cnt_r <= 4'h0;
    end else if (!busy_r || m_tick) begin
      half_cnt_r <= 4'h0;
    end else if (!stop_mode) begin
      half_cnt_r <= half_cnt_r + 4'h1;
    end
  end

  // Master clock output level
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sck_r <= 1'b1;
    end else if (!serial_en || !master_select) begin
      sck_r <= 1'b1;
    end else if (m_tick) begin
      sck_r <= !sck_r;
    end
  end

  // ==========================================================
  // Exchange sequencing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      start_pend_r <= 1'b0;
      cnt_r <= 3'h0;
    end else if (!serial_en) begin
      busy_r <= 1'b0;
      start_pend_r <= 1'b0;
      cnt_r <= 3'h0;
    end else begin
      if (acc_ok && bus_wr && master_select) begin
        start_pend_r <= 1'b1;
      end else if (start_pend_r && fifo_in_ready) begin
        start_pend_r <= 1'b0;
        busy_r <= 1'b1;
      end
      if (fall && !busy_r && !master_select) begin
        busy_r <= 1'b1;
      end
      if (rise && busy_r) begin
        cnt_r <= cnt_r + 3'h1;
      end
      if (last_rise) begin
        busy_r <= 1'b0;
      end
    end
  end

  // Shift register: storage when idle, never reset
  always_ff @(posedge clock) begin
    if (acc_ok && bus_wr) begin
      shift_data_register <= bus_wdata;
    end else if (rise && busy_r) begin
      if (bit_order_select) begin
        shift_data_register <= {sdi_s, shift_data_register[7:1]};
      end else begin
        shift_data_register <= {shift_data_register[6:0], sdi_s};
      end
    end
  end

  // Data output bit, loaded by a data write, then moved on falling edges after the first
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sdo_r <= 1'b1;
    end else if (acc_ok && bus_wr) begin
      sdo_r <= bit_order_select ? bus_wdata[0] : bus_wdata[7];
    end else if (fall && busy_r && cnt_r != 3'h0) begin
      sdo_r <= bit_order_select ? shift_data_register[0] : shift_data_register[7];
    end
  end

  // ==========================================================
  // Status flags
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      transfer_done_flag <= 1'b0;
      done_pend_r <= 1'b0;
    end else begin
      if (done_set) begin
        transfer_done_flag <= 1'b1;
      end else if (seq_clr) begin
        transfer_done_flag <= 1'b0;
      end
      if (last_rise && stop_mode && !master_select) begin
        done_pend_r <= 1'b1;
      end else if (!stop_mode) begin
        done_pend_r <= 1'b0;
      end
    end
  end

  // Status-read arming for the clear sequence
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      armed_r <= 1'b0;
    end else if (!transfer_done_flag || seq_clr) begin
      armed_r <= 1'b0;
    end else if (st_rd) begin
      armed_r <= 1'b1;
    end
  end

  // Collision flag, set wins over clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      access_collision_flag <= 1'b0;
    end else if (col_evt) begin
      access_collision_flag <= 1'b1;
    end else if (seq_clr) begin
      access_collision_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Outputs; interrupt unaffected by wait, so it can wake the CPU
  assign serial_interrupt_request = transfer_irq_enable
    && (transfer_done_flag || done_pend_r);
  assign sck_out = sck_r;
  assign sck_oe_n = !(serial_en && master_select);
  assign sdo_out = sdo_r;
  assign sdo_oe_n = !serial_en;

  // Received byte enters buffer the cycle after completion
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      push_r <= 1'b0;
    end else begin
      push_r <= last_rise;
    end
  end

  byte_fifo #(.WIDTH(serial_pkg::BYTE_W), .DEPTH(serial_pkg::RX_DEPTH)) u_rx_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(push_r),
    .in_ready(fifo_in_ready),
    .in_data(shift_data_register),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence arm_seq;
    st_rd && transfer_done_flag;
  endsequence

  sequence data_seq;
    dat_acc && !done_set && !busy_any;
  endsequence

  a_done_on_eighth: assert property (last_rise && !stop_mode |=> transfer_done_flag)
    else $error("done flag not set after eighth edge");
  a_irq_follows_done: assert property (transfer_irq_enable && transfer_done_flag
    |-> serial_interrupt_request)
    else $error("interrupt missing with done set");
  a_locked_access: assert property (bus_wr && bus_addr == serial_pkg::DATA_OFF
    && transfer_done_flag && !armed_r |=> transfer_done_flag && !start_pend_r)
    else $error("data access taken while locked");
  a_no_shift_done: assert property (transfer_done_flag && $stable(transfer_done_flag)
    |-> $stable(cnt_r))
    else $error("bit count moved while done");
  a_clear_sequence: assert property (arm_seq ##1 !dat_acc ##1 data_seq
    |=> !transfer_done_flag && !access_collision_flag)
    else $error("clear sequence failed");
  a_collision_set: assert property (dat_acc && busy_r && !rise
    |=> access_collision_flag && $stable(cnt_r))
    else $error("collision not flagged");
  a_col_no_irq: assert property (!transfer_done_flag && !done_pend_r
    |-> !serial_interrupt_request)
    else $error("interrupt without done");
  a_status_zero: assert property (st_rd |=> bus_rdata[5:0] == 6'h00)
    else $error("status low bits not zero");
  a_master_start: assert property (bus_wr && bus_addr == serial_pkg::DATA_OFF && acc_ok
    && master_select && serial_en && fifo_in_ready |=> ##1 busy_r)
    else $error("master exchange did not start");
  a_sck_idle: assert property (serial_en && master_select && !busy_r |-> sck_out)
    else $error("master clock not idle high");
  a_stop_hold: assert property (stop_mode && $past(stop_mode) && master_select
    && !$past(bus_wr) |-> $stable(sck_out) && $stable(sdo_out))
    else $error("pins moved during stop");
endmodule
